// ### src/adcr_defs.vh
// Constants for the converter serial readout control block
//
// Behaviour
// [R1] Chip select low: lock, then convert continuously
// [R2] Chip select high: abort, float pins, standby
// [R3] Deselect discards the held output word
// [R4] Data-ready high throughout each conversion
// [R5] Data-ready low flags result; slave interrupt
// [R6] Unread result: data-ready high before update
// [R7] Master: ready low half period before clocks (code: low 1.5 crystal periods)
// [R8] Data changes on falling, sampled on rising
// [R9] Mode pin 0 master, 1 slave
// [R10] Word rate is crystal over 69*8*3
// [R11] First settled result after two word periods
// [R12] Decimation period places 50/60 Hz notches
// [R13] Master drives serial clock, one crystal period
// [R14] Master: 24 clocks, then clock idles high
// [R15] Slave: host idles clock high, 24 pulses
// [R16] Result is 24-bit offset binary
// [R17] MSB first, then data-ready back high
// [R18] Slave batches keep the shift position
`ifndef ADCR_DEFS_VH
`define ADCR_DEFS_VH

// ****************************************************************
// Word rate and sequencing
// ****************************************************************
`define ADCR_DEC_A 69
`define ADCR_DEC_B 8
`define ADCR_DEC_C 3
`define ADCR_WORD_XT (`ADCR_DEC_A * `ADCR_DEC_B * `ADCR_DEC_C)
`define ADCR_SETTLE_WORDS 2
`define ADCR_LOCK_XT 8
`define ADCR_WARN_XT 4

// ****************************************************************
// Serial word
// ****************************************************************
`define ADCR_WORD_BITS 24
`define ADCR_MODE_MASTER 1'b0
`define ADCR_MODE_SLAVE 1'b1

`endif

// ### src/adcr_buf2.v
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
`include "adcr_defs.vh"

module adcr_buf2 #(
    parameter W = `ADCR_WORD_BITS
) (
    input wire sys_clk,         // System clock
    input wire reset,           // Synchronous reset, high
    input wire flush,           // Drop all entries
    input wire [W-1:0] inData,  // Filling side data
    input wire inValid,         // Filling side valid
    output reg inReady_r,       // Room for a word
    output wire [W-1:0] outData, // Oldest word
    output wire outValid,       // A word is held
    input wire outReady         // Draining side takes word
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    reg [W-1:0] ent0_r; // Head entry
    reg [W-1:0] ent1_r; // Second entry
    reg [1:0] cnt_r;    // Entries held
    reg [1:0] cnt_nxt;  // Next entry count
    wire push;          // Word accepted
    wire pop;           // Word removed

    assign outData = ent0_r;
    assign outValid = (cnt_r != 2'h0);
    assign push = inValid && inReady_r;
    assign pop = outValid && outReady;

    // Count update
    always @* begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
        end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
        end
    end

    // Entries, count and registered ready
    always @(posedge sys_clk) begin
        if (reset || flush) begin
            cnt_r <= 2'h0;
            inReady_r <= 1'b1;
            ent0_r <= {W{1'b0}};
            ent1_r <= {W{1'b0}};
        end else begin
            cnt_r <= cnt_nxt;
            inReady_r <= (cnt_nxt != 2'h2);
            if (pop) begin
                // Shift forward, or a new word goes straight to the head
                ent0_r <= (cnt_r == 2'h2) ? ent1_r : inData;
                if (push) begin
                    ent1_r <= inData;
                end
            end else if (push) begin
                if (cnt_r == 2'h0) begin
                    ent0_r <= inData;
                end else begin
                    ent1_r <= inData;
                end
            end
        end
    end
endmodule

// ### src/adcr_readout.v
// Serial result readout and conversion sequencing of the converter
`timescale 1ns/100ps
`include "adcr_defs.vh"

module adcr_readout #(
    parameter WORD_XT = `ADCR_WORD_XT,  // Crystal periods per word
    parameter LOCK_XT = `ADCR_LOCK_XT,  // Crystal periods to lock
    parameter WARN_XT = `ADCR_WARN_XT,  // Warning lead before update
    parameter NBITS = `ADCR_WORD_BITS   // Bits per result
) (
    input wire sys_clk,             // System clock, 50 MHz
    input wire reset,               // Synchronous reset, high
    input wire crystal_clock,       // Crystal clock pin
    input wire csN,                 // Chip select pin, low active
    input wire modeSel,             // 0 master, 1 slave
    input wire sclkIn,              // Serial clock pin level
    output reg sclkOut_r,           // Serial clock drive value
    output reg sclkOeN_r,           // Serial clock enable, low drives
    output reg doutRdyOut_r,        // Data/ready drive value
    output reg doutRdyOeN_r,        // Data/ready enable, low drives
    input wire [NBITS-1:0] filtData, // Filter result, offset binary
    input wire filtValid,           // Filter result valid
    output wire filtReady           // Buffer can take a result
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [1:0] CV_IDLE = 2'h0; // Standby
    localparam [1:0] CV_LOCK = 2'h1; // Clock multiplier locking
    localparam [1:0] CV_RUN = 2'h2;  // Converting
    localparam [1:0] SH_EMPTY = 2'h0; // No word held
    localparam [1:0] SH_READY = 2'h1; // Word held, ready low
    localparam [1:0] SH_ARMED = 2'h2; // Master: one full period seen
    localparam [1:0] SH_SHIFT = 2'h3; // Bits going out

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    reg [1:0] xtSync_r;   // Crystal clock stages
    reg [1:0] csSync_r;   // Chip select stages
    reg [1:0] modeSync_r; // Mode stages
    reg [1:0] skSync_r;   // Serial clock stages
    reg xtPrev_r;         // Crystal level one cycle back
    reg skPrev_r;         // Serial clock level one cycle back

    // Two flops on each pin before any logic
    always @(posedge sys_clk) begin
        if (reset) begin
            xtSync_r <= 2'h0;
            csSync_r <= 2'h3;
            modeSync_r <= 2'h0;
            skSync_r <= 2'h3;
            xtPrev_r <= 1'b0;
            skPrev_r <= 1'b1;
        end else begin
            xtSync_r <= {xtSync_r[0], crystal_clock};
            csSync_r <= {csSync_r[0], csN};
            modeSync_r <= {modeSync_r[0], modeSel};
            skSync_r <= {skSync_r[0], sclkIn};
            xtPrev_r <= xtSync_r[1];
            skPrev_r <= skSync_r[1];
        end
    end

    wire xtRise = xtSync_r[1] && !xtPrev_r;  // Crystal rising edge
    wire xtFall = !xtSync_r[1] && xtPrev_r;  // Crystal falling edge
    wire skRise = skSync_r[1] && !skPrev_r;  // Host clock rising edge
    wire skFall = !skSync_r[1] && skPrev_r;  // Host clock falling edge
    wire selected = !csSync_r[1];             // Chip selected
    wire slave = (modeSync_r[1] == `ADCR_MODE_SLAVE); // Slave operation

    // ****************************************************************
    // Result buffer
    // ****************************************************************
    wire [NBITS-1:0] bufData; // Oldest filter result
    wire bufValid;            // Buffer holds a result
    reg bufTake;              // Result taken at update

    adcr_buf2 #(
        .W(NBITS)
    ) u_buf (
        .sys_clk(sys_clk),
        .reset(reset),
        .flush(!selected), // [R3]
        .inData(filtData),
        .inValid(filtValid),
        .inReady_r(filtReady),
        .outData(bufData),
        .outValid(bufValid),
        .outReady(bufTake)
    );

    // ****************************************************************
    // Conversion sequencing
    // ****************************************************************
    reg [1:0] cvState_r;   // Sequencer state
    reg [15:0] xtCnt_r;    // Crystal periods in lock or word
    reg [1:0] settle_r;    // Word periods since start, stops at 1
    reg [1:0] shState_r;   // Shifter state
    reg [NBITS-1:0] shReg_r; // Output shift register
    reg [5:0] bitCnt_r;    // Bits sent

    wire wordEnd = (cvState_r == CV_RUN) && xtRise &&
        (xtCnt_r == WORD_XT - 1);          // Conversion complete
    wire warnPt = (cvState_r == CV_RUN) && xtRise &&
        (xtCnt_r == WORD_XT - 1 - WARN_XT); // Update about to occur
    wire settled = (settle_r >= `ADCR_SETTLE_WORDS - 1); // Output valid

    // Take a buffered result at the settled word boundary
    always @* begin
        bufTake = wordEnd && settled && bufValid; // [R11]
    end

    // Lock, then free-running word period counter
    always @(posedge sys_clk) begin
        if (reset || !selected) begin
            cvState_r <= CV_IDLE; // [R2]
            xtCnt_r <= 16'h0000;
            settle_r <= 2'h0;
        end else begin
            case (cvState_r)
                CV_IDLE: begin
                    // Selected: start locking
                    cvState_r <= CV_LOCK; // [R1]
                    xtCnt_r <= 16'h0000;
                end
                CV_LOCK: begin
                    // Count crystal periods until lock
                    if (xtRise) begin
                        if (xtCnt_r == LOCK_XT - 1) begin
                            cvState_r <= CV_RUN; // [R1]
                            xtCnt_r <= 16'h0000;
                        end else begin
                            xtCnt_r <= xtCnt_r + 16'h0001;
                        end
                    end
                end
                CV_RUN: begin
                    // Word period of 69*8*3 crystal periods
                    if (xtRise) begin
                        if (xtCnt_r == WORD_XT - 1) begin
                            xtCnt_r <= 16'h0000; // [R10] [R12]
                            if (!settled) begin
                                settle_r <= settle_r + 2'h1; // [R11]
                            end
                        end else begin
                            xtCnt_r <= xtCnt_r + 16'h0001;
                        end
                    end
                end
                default: begin
                    cvState_r <= CV_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Serial shifter and pin drive
    // ****************************************************************
    wire fallEv = slave ? skFall : xtFall; // [R9]
    wire riseEv = slave ? skRise : xtRise; // [R9]

    always @(posedge sys_clk) begin
        if (reset || !selected) begin
            // Standby: both pins floated, word lost
            shState_r <= SH_EMPTY;                   // [R2]
            shReg_r <= {NBITS{1'b0}};                // [R3]
            bitCnt_r <= 6'h00;
            sclkOut_r <= 1'b1;
            sclkOeN_r <= 1'b1;                       // [R2]
            doutRdyOut_r <= 1'b1;
            doutRdyOeN_r <= 1'b1;                    // [R2]
        end else begin
            doutRdyOeN_r <= 1'b0;
            sclkOeN_r <= slave;                      // [R9] [R13]
            if (bufTake) begin
                // New offset-binary result: ready low
                shReg_r <= bufData;                  // [R16]
                shState_r <= SH_READY;
                bitCnt_r <= 6'h00;
                sclkOut_r <= 1'b1;
                doutRdyOut_r <= 1'b0;                // [R5]
            end else if (warnPt && shState_r == SH_READY) begin
                // Unread word: ready high before update
                shState_r <= SH_EMPTY;               // [R6]
                doutRdyOut_r <= 1'b1;                // [R6]
            end else begin
                case (shState_r)
                    SH_EMPTY: begin
                        // Converting: line held high
                        doutRdyOut_r <= 1'b1;        // [R4]
                        sclkOut_r <= 1'b1;
                    end
                    SH_READY: begin
                        if (!slave) begin
                            // Wait a crystal rise: one full period low
                            if (xtRise) begin
                                shState_r <= SH_ARMED; // [R7]
                            end
                        end else if (fallEv) begin
                            // Host first falling edge: MSB out
                            doutRdyOut_r <= shReg_r[NBITS-1]; // [R8] [R17]
                            shReg_r <= {shReg_r[NBITS-2:0], 1'b0};
                            bitCnt_r <= 6'h01;
                            shState_r <= SH_SHIFT;
                        end
                    end
                    SH_ARMED: begin
                        if (fallEv) begin
                            // Master first clock low, MSB out
                            sclkOut_r <= 1'b0;       // [R13]
                            doutRdyOut_r <= shReg_r[NBITS-1]; // [R8] [R17]
                            shReg_r <= {shReg_r[NBITS-2:0], 1'b0};
                            bitCnt_r <= 6'h01;
                            shState_r <= SH_SHIFT;
                        end
                    end
                    SH_SHIFT: begin
                        if (riseEv) begin
                            sclkOut_r <= 1'b1;
                            if (bitCnt_r == NBITS) begin
                                // Last bit sampled: idle high
                                shState_r <= SH_EMPTY; // [R14] [R17]
                                doutRdyOut_r <= 1'b1;  // [R17]
                            end
                        end else if (fallEv && bitCnt_r != NBITS) begin
                            // Next bit; slave pauses hold position
                            sclkOut_r <= slave;      // [R14]
                            doutRdyOut_r <= shReg_r[NBITS-1]; // [R8] [R18]
                            shReg_r <= {shReg_r[NBITS-2:0], 1'b0};
                            bitCnt_r <= bitCnt_r + 6'h01;
                        end
                    end
                    default: begin
                        shState_r <= SH_EMPTY;
                    end
                endcase
            end
        end
    end
endmodule

// ### tb/adcr_readout_checker.sv
// Port assertions for the converter serial readout block
`timescale 1ns/100ps
module adcr_readout_checker #(
    parameter WORD_XT = 1656  // Crystal periods per word
) (
    input wire sys_clk,  // System clock
    input wire reset,  // Synchronous reset, high
    input wire csN,  // Chip select pin
    input wire modeSel,  // Mode pin
    input wire sclkOut_r,  // Serial clock drive value
    input wire sclkOeN_r,  // Serial clock enable, low drives
    input wire doutRdyOut_r,  // Data/ready drive value
    input wire doutRdyOeN_r  // Data/ready enable, low drives
);
localparam int SETTLE = 2 * WORD_XT * 8;  // Two word periods in system cycles
reg [15:0] selCnt_r;  // Cycles spent selected
reg [5:0] fallCnt_r;  // Clock falls in this burst
// Count selected time and clock falls
always @(posedge sys_clk) begin
    if (reset || csN) begin
        selCnt_r <= 16'h0000;
    end else if (selCnt_r != 16'hFFFF) begin
        selCnt_r <= selCnt_r + 16'h0001;
    end
    if (reset || sclkOeN_r || ($fell(doutRdyOut_r) && sclkOut_r)) begin
        fallCnt_r <= 6'h00;
    end else if ($fell(sclkOut_r)) begin
        fallCnt_r <= fallCnt_r + 6'h01;
    end
end
default clocking cb @(posedge sys_clk); endclocking
default disable iff (reset);
chk_float_when_off: assert property (csN[*5] |-> doutRdyOeN_r && sclkOeN_r)
    else $error("pins driven while deselected");
chk_slave_no_drive: assert property (modeSel[*5] |-> sclkOeN_r)
    else $error("clock driven in slave mode");
chk_master_drives: assert property ((!csN && !modeSel)[*6] |-> !sclkOeN_r)
    else $error("clock not driven in master mode");
chk_start_high: assert property (
    !doutRdyOeN_r && $past(doutRdyOeN_r) |-> doutRdyOut_r)
    else $error("data-ready low at conversion start");
chk_ready_half: assert property (
    $fell(doutRdyOut_r) && sclkOut_r && !sclkOeN_r |-> sclkOut_r[*4])
    else $error("clock began too soon after ready");
chk_clock_period: assert property (
    $fell(sclkOut_r) && !sclkOeN_r |-> !sclkOut_r[*4] ##1 sclkOut_r)
    else $error("serial clock low phase wrong");
chk_burst_count: assert property (
    $fell(sclkOut_r) && !sclkOeN_r |-> fallCnt_r < 6'd24)
    else $error("more than 24 clocks in a burst");
chk_idle_after: assert property (
    $rose(sclkOut_r) && fallCnt_r == 6'd24 |-> ##2 (sclkOut_r && doutRdyOut_r)[*6])
    else $error("clock or data not idle after word");
chk_settle_time: assert property (
    $fell(doutRdyOut_r) && !doutRdyOeN_r |-> selCnt_r >= SETTLE)
    else $error("result before settling time");
endmodule
bind adcr_readout adcr_readout_checker #(.WORD_XT(WORD_XT)) adcr_readout_checker_i (
    .sys_clk(sys_clk), .reset(reset), .csN(csN), .modeSel(modeSel),
    .sclkOut_r(sclkOut_r), .sclkOeN_r(sclkOeN_r),
    .doutRdyOut_r(doutRdyOut_r), .doutRdyOeN_r(doutRdyOeN_r));

// ### tb/adcr_host_model.sv
// Host serial port model reading results in slave mode
`timescale 1ns/100ps
module adcr_host_model (
    input wire sys_clk,  // System clock
    input wire doutPin,  // Data/ready pin level
    output reg hostSclk  // Host serial clock drive
);
initial hostSclk = 1'b1;  // Idles high between transfers
// Clock n bits in, sampling on each rising edge
task readBits(input integer n, inout reg [23:0] w);
    integer k;
    begin
        for (k = 0; k < n; k = k + 1) begin
            @(negedge sys_clk);
            hostSclk = 1'b0;  // Falling edge moves data
            repeat (5) @(negedge sys_clk);
            hostSclk = 1'b1;  // Rising edge samples data
            w = {w[22:0], doutPin};
            repeat (2) @(negedge sys_clk);
        end
    end
endtask
endmodule

// ### tb/adcr_readout_tb.sv
// Testbench for the converter serial readout block
`timescale 1ns/100ps
module adcr_readout_tb;
// ****************************************************************
// Pins, clocks and instances
// ****************************************************************
localparam WXT = 60;  // Shortened word length
localparam WCY = WXT * 8;  // System cycles per word
reg sys_clk = 1'b0;  // System clock
reg reset = 1'b1;  // Reset, high
reg crystal_clock = 1'b0;  // Crystal pin
reg csN = 1'b1;  // Chip select pin
reg modeSel = 1'b1;  // Mode pin
reg [23:0] filtData = 24'h000000;  // Filter word
reg filtValid = 1'b0;  // Filter valid
reg doutLast = 1'b1;  // Last driven data level
wire sclkOut, sclkOeN, doutOut, doutOeN, filtReady, hostSclk;  // Block pins
wire sclkPin = !sclkOeN ? sclkOut : hostSclk;  // Resolved clock pin
wire doutPin = !doutOeN ? doutOut : ~doutLast;  // Floated pin keeps no value
integer fails = 0;  // Mismatch count
integer compares = 0;  // Comparison count
integer cyc = 0;  // Cycle count
integer tSel = 0;  // Cycle of selection
initial forever #10 sys_clk = ~sys_clk;
// Crystal offset from system edges
initial begin
    #3;
    forever #80 crystal_clock = ~crystal_clock;
end
adcr_readout #(.WORD_XT(WXT), .LOCK_XT(2)) adcr_readout_i (.sys_clk(sys_clk),
    .reset(reset), .crystal_clock(crystal_clock), .csN(csN), .modeSel(modeSel),
    .sclkIn(sclkPin), .sclkOut_r(sclkOut), .sclkOeN_r(sclkOeN), .doutRdyOut_r(doutOut),
    .doutRdyOeN_r(doutOeN), .filtData(filtData), .filtValid(filtValid),
    .filtReady(filtReady));
adcr_host_model adcr_host_model_i (.sys_clk(sys_clk), .doutPin(doutPin),
    .hostSclk(hostSclk));
// Cycle count, floated level, hang limit
always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (!doutOeN) doutLast <= doutOut;
    if (cyc == 20000) begin
        fails = fails + 1;
        $display("BAD %0t run hung", $time);
        test_done;
    end
end
// ****************************************************************
// Compare and helper tasks
// ****************************************************************
task cmpWord(input [23:0] got, input [23:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    end
endtask
task cmpFlag(input got, input exp);
    begin
        compares = compares + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    end
endtask
// Deselect, then select again with a new filter word
task reselect(input mode, input [23:0] word);
    begin
        @(negedge sys_clk);
        csN = 1'b1;
        filtValid = 1'b0;
        repeat (6) @(negedge sys_clk);
        cmpFlag(doutOeN && sclkOeN, 1'b1);
        cmpFlag(filtReady, 1'b1);
        modeSel = mode;
        filtData = word;
        filtValid = 1'b1;
        csN = 1'b0;
        tSel = cyc;
        repeat (6) @(negedge sys_clk);
        cmpFlag(doutOeN, 1'b0);
        cmpFlag(doutPin, 1'b1);
        cmpFlag(filtReady, 1'b0);
    end
endtask
// Wait for data-ready low, bounded
task waitReady(output integer t);
    integer k;
    begin
        k = 0;
        while (doutPin !== 1'b0 && k < 1200) begin
            @(negedge sys_clk);
            k = k + 1;
        end
        t = cyc;
        cmpFlag(k < 1200, 1'b1);
    end
endtask
// ****************************************************************
// Scenarios
// ****************************************************************
task slaveRead(input [23:0] word);
    reg [23:0] got;
    integer t1, t2;
    begin
        reselect(1'b1, word);
        waitReady(t1);
        cmpFlag(t1 - tSel >= 2 * WCY, 1'b1);
        adcr_host_model_i.readBits(8, got);
        repeat (40) @(negedge sys_clk);
        adcr_host_model_i.readBits(16, got);
        cmpWord(got, word);
        repeat (6) @(negedge sys_clk);
        cmpFlag(doutPin, 1'b1);
        waitReady(t2);
        cmpFlag(t2 - t1 == WCY, 1'b1);
    end
endtask
task masterRead(input [23:0] word);
    reg [23:0] got;
    reg bitV;
    integer t1, k;
    begin
        reselect(1'b0, word);
        waitReady(t1);
        // Keep the last settled data level seen before each clock rise
        for (k = 0; k < 24; k = k + 1) begin
            while (sclkPin !== 1'b0) @(negedge sys_clk);
            while (sclkPin === 1'b0) begin
                bitV = doutPin;
                @(negedge sys_clk);
            end
            got = {got[22:0], bitV};
        end
        cmpWord(got, word);
        repeat (40) @(negedge sys_clk);
        cmpFlag(sclkPin && doutPin, 1'b1);
    end
endtask
task unreadWord;
    integer t1, t2, k;
    begin
        reselect(1'b1, 24'h123456);
        waitReady(t1);
        k = 0;
        while (doutPin !== 1'b1 && k < WCY) begin
            @(negedge sys_clk);
            k = k + 1;
        end
        cmpFlag(k < WCY, 1'b1);
        waitReady(t2);
        cmpFlag(t2 - t1 == WCY, 1'b1);
    end
endtask
task abortRead;
    reg [23:0] got;
    integer t1;
    begin
        reselect(1'b1, 24'h000000);
        waitReady(t1);
        adcr_host_model_i.readBits(8, got);
        cmpWord({16'h0000, got[7:0]}, 24'h000000);
        reselect(1'b1, 24'hFFFFFF);
        waitReady(t1);
        cmpFlag(t1 - tSel >= 2 * WCY, 1'b1);
        adcr_host_model_i.readBits(24, got);
        cmpWord(got, 24'hFFFFFF);
    end
endtask
// Report counts, verdict, end of run
task test_done;
    begin
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    end
endtask
// Main sequence
initial begin
    repeat (10) @(negedge sys_clk);
    reset = 1'b0;
    slaveRead(24'h800000);
    masterRead(24'hA5C3F0);
    unreadWord;
    abortRead;
    test_done;
end
endmodule
